// ---- rtl/line_trig_pkg.sv ----
// package: constants for the line acquisition trigger sequencer
package line_trig_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [7:0] CTRL_ADDR        = 8'h00;
    localparam logic [7:0] CMD_ADDR         = 8'h04;
    localparam logic [7:0] FRAME_CNT_ADDR   = 8'h08;
    localparam logic [7:0] LINES_ADDR       = 8'h0c;
    localparam logic [7:0] EXP_TIME_ADDR    = 8'h10;
    localparam logic [7:0] STATUS_ADDR      = 8'h14;
    localparam logic [7:0] READOUT_US_ADDR  = 8'h18;
    localparam logic [7:0] OVT_LINE_ADDR    = 8'h1c;
    localparam logic [7:0] OVT_ACQ_ADDR     = 8'h20;

    // control and command register field positions
    localparam int CTRL_CONT_BIT   = 0;
    localparam int CTRL_ACQ_TRIG   = 1;
    localparam int CTRL_LINE_TRIG  = 2;
    localparam int CTRL_WIDTH_MODE = 3;
    localparam int CTRL_OH_UNLIM   = 4;
    localparam int CTRL_ACQ_FALL   = 5;
    localparam int CTRL_W          = 6;
    localparam int CMD_START_BIT   = 0;
    localparam int CMD_STOP_BIT    = 1;

    // reset values
    localparam logic [5:0]  CTRL_RST      = 6'h06;
    localparam logic [15:0] FRAME_CNT_RST = 16'h0001;
    localparam logic [15:0] LINES_RST     = 16'h0003;
    localparam logic [15:0] EXP_TIME_RST  = 16'h0028;

    // timing
    localparam int  CLK_MHZ        = 20;
    // overhead in tenths of a us: integer maths keeps the count exact
    localparam int  OH_DEFAULT_DUS = 54;
    localparam int  OH_REDUCED_DUS = 34;
    // exposure overhead: least time, rounded up to whole cycles
    localparam int  OH_DEFAULT_CYC = (OH_DEFAULT_DUS * CLK_MHZ + 9) / 10;
    localparam int  OH_REDUCED_CYC = (OH_REDUCED_DUS * CLK_MHZ + 9) / 10;
    localparam int  READOUT_CYC    = 200;
    localparam logic [15:0] CYC_W  = 16'h0000;

    typedef enum logic [1:0] {
        EXP_IDLE,
        EXP_RUN,
        EXP_HOLD,
        EXP_OVERHEAD
    } exp_state_t;
endpackage : line_trig_pkg

// ---- rtl/edge_sync.sv ----
// module: two-stage pin synchroniser with edge pulses
`timescale 1ns/1ns
module edge_sync (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~prev_reg;
    assign fall_o  = ~sync_reg & prev_reg;
endmodule : edge_sync

// ---- rtl/line_trig_ctrl.sv ----
// module: line acquisition trigger sequencer with apb registers
`timescale 1ns/1ns
module line_trig_ctrl #(
    parameter int READOUT_CYCLES = line_trig_pkg::READOUT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        acq_trigger_input_i,
    input  wire logic        external_line_trigger_input_i,
    output logic             exposure_active_o,
    output logic             readout_active_o,
    output logic             line_trigger_wait_o,
    output logic             acq_trigger_wait_o,
    output logic             frame_start_o,
    output logic             line_overtrigger_o,
    output logic             acq_overtrigger_o
);
    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [5:0]  ctrl_reg;
    logic [15:0] frame_cnt_reg;
    logic [15:0] lines_reg;
    logic [15:0] exp_time_reg;
    logic [15:0] ovt_line_reg;
    logic [15:0] ovt_acq_reg;
    logic        running_reg;
    logic        armed_reg;
    logic [15:0] frames_done_reg;
    logic [15:0] lines_done_reg;
    logic [15:0] exp_cnt_reg;
    logic [15:0] ro_cnt_reg;
    logic        ro_busy_reg;
    logic        ro_pending_reg;
    line_trig_pkg::exp_state_t exp_state_reg;

    logic acq_lvl;
    logic acq_rise;
    logic acq_fall;
    logic line_lvl;
    logic line_rise;
    logic line_fall;

    edge_sync u_acq_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (acq_trigger_input_i),
        .level_o   (acq_lvl),
        .rise_o    (acq_rise),
        .fall_o    (acq_fall)
    );

    edge_sync u_line_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (external_line_trigger_input_i),
        .level_o   (line_lvl),
        .rise_o    (line_rise),
        .fall_o    (line_fall)
    );

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    logic bus_wr;
    logic bus_rd;
    logic start_cmd;
    logic stop_cmd;
    logic cont_mode;
    logic acq_trig_on;
    logic width_mode;
    logic acq_edge;
    logic line_req;
    logic awaiting_line;
    logic line_accept;
    logic exp_end;
    logic line_ready_out;
    logic frame_last_line;
    logic frames_reached;
    logic [15:0] oh_cycles;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] b);
        addr_hit = (a == b);
    endfunction : addr_hit

    assign bus_wr      = psel & penable & pwrite;
    assign bus_rd      = psel & ~pwrite;
    assign start_cmd   = bus_wr & addr_hit(paddr, line_trig_pkg::CMD_ADDR)
                         & pwdata[line_trig_pkg::CMD_START_BIT];
    assign stop_cmd    = bus_wr & addr_hit(paddr, line_trig_pkg::CMD_ADDR)
                         & pwdata[line_trig_pkg::CMD_STOP_BIT];
    assign cont_mode   = ctrl_reg[line_trig_pkg::CTRL_CONT_BIT];
    assign acq_trig_on = ctrl_reg[line_trig_pkg::CTRL_ACQ_TRIG];
    assign width_mode  = ctrl_reg[line_trig_pkg::CTRL_WIDTH_MODE];
    assign oh_cycles   = ctrl_reg[line_trig_pkg::CTRL_OH_UNLIM]
                         ? 16'(line_trig_pkg::OH_REDUCED_CYC)
                         : 16'(line_trig_pkg::OH_DEFAULT_CYC);
    assign acq_edge    = ctrl_reg[line_trig_pkg::CTRL_ACQ_FALL]
                         ? acq_fall : acq_rise;
    // free-run line starts when line triggering is off
    assign line_req    = ctrl_reg[line_trig_pkg::CTRL_LINE_TRIG]
                         ? line_rise : 1'b1;
    // frame starts have no pin of their own: lines are awaited once armed
    assign awaiting_line = running_reg & armed_reg
                           & (exp_state_reg == line_trig_pkg::EXP_IDLE);
    assign line_accept = awaiting_line & line_req;
    // overlap is decided only by timing: no mode bit exists
    assign exp_end = (exp_state_reg == line_trig_pkg::EXP_RUN)
                     & (width_mode ? line_fall
                                   : (exp_cnt_reg >= exp_time_reg));
    // a finished exposure hands over when the readout path is free or in its last cycle: timed mode waits in hold, width mode until a later line fall
    assign line_ready_out = ~ro_busy_reg | (ro_cnt_reg == 16'h0001);
    assign frame_last_line = (lines_done_reg + 16'h0001 >= lines_reg);
    assign frames_reached  = (frames_done_reg + 16'h0001 >= frame_cnt_reg);

    // ------------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg      <= line_trig_pkg::CTRL_RST;
            frame_cnt_reg <= line_trig_pkg::FRAME_CNT_RST;
            lines_reg     <= line_trig_pkg::LINES_RST;
            exp_time_reg  <= line_trig_pkg::EXP_TIME_RST;
        end else if (bus_wr) begin
            case (paddr)
                line_trig_pkg::CTRL_ADDR:
                    ctrl_reg <= pwdata[5:0];
                line_trig_pkg::FRAME_CNT_ADDR:
                    frame_cnt_reg <= pwdata[15:0];
                line_trig_pkg::LINES_ADDR:
                    lines_reg <= pwdata[15:0];
                line_trig_pkg::EXP_TIME_ADDR:
                    exp_time_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // zero-wait slave: answer in the access phase
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (bus_rd & ~penable) begin
                case (paddr)
                    line_trig_pkg::CTRL_ADDR:
                        prdata <= {26'h0, ctrl_reg};
                    line_trig_pkg::CMD_ADDR:
                        prdata <= 32'h0000_0000;
                    line_trig_pkg::FRAME_CNT_ADDR:
                        prdata <= {16'h0, frame_cnt_reg};
                    line_trig_pkg::LINES_ADDR:
                        prdata <= {16'h0, lines_reg};
                    line_trig_pkg::EXP_TIME_ADDR:
                        prdata <= {16'h0, exp_time_reg};
                    line_trig_pkg::STATUS_ADDR:
                        prdata <= {26'h0, armed_reg, running_reg,
                                   ro_busy_reg, exposure_active_o,
                                   acq_trigger_wait_o,
                                   line_trigger_wait_o};
                    line_trig_pkg::READOUT_US_ADDR:
                        prdata <= 32'(READOUT_CYCLES
                                      / line_trig_pkg::CLK_MHZ);
                    line_trig_pkg::OVT_LINE_ADDR:
                        prdata <= {16'h0, ovt_line_reg};
                    line_trig_pkg::OVT_ACQ_ADDR:
                        prdata <= {16'h0, ovt_acq_reg};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end else if (psel & ~penable) begin
                prdata  <= 32'h0000_0000;
                pslverr <= ~(paddr <= line_trig_pkg::OVT_ACQ_ADDR
                             && paddr[1:0] == 2'b00);
            end
        end
    end

    // ------------------------------------------------------------------
    // acquisition sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            running_reg     <= 1'b0;
            armed_reg       <= 1'b0;
            frames_done_reg <= 16'h0000;
            lines_done_reg  <= 16'h0000;
        end else if (stop_cmd) begin
            running_reg <= 1'b0;
            armed_reg   <= 1'b0;
        end else if (start_cmd) begin
            running_reg     <= 1'b1;
            armed_reg       <= ~acq_trig_on;
            frames_done_reg <= 16'h0000;
            lines_done_reg  <= 16'h0000;
        end else if (running_reg) begin
            if (!armed_reg && acq_edge) begin
                armed_reg       <= 1'b1;
                frames_done_reg <= 16'h0000;
            end
            if (line_accept) begin
                if (frame_last_line) begin
                    lines_done_reg  <= 16'h0000;
                    frames_done_reg <= frames_done_reg + 16'h0001;
                    if (frames_reached) begin
                        frames_done_reg <= 16'h0000;
                        armed_reg <= ~acq_trig_on;
                        if (!cont_mode && !acq_trig_on) begin
                            running_reg <= 1'b0;
                        end
                    end
                end else begin
                    lines_done_reg <= lines_done_reg + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // exposure and overhead
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exp_state_reg <= line_trig_pkg::EXP_IDLE;
            exp_cnt_reg   <= 16'h0000;
        end else begin
            case (exp_state_reg)
                line_trig_pkg::EXP_IDLE: begin
                    exp_cnt_reg <= 16'h0001;
                    if (line_accept) begin
                        exp_state_reg <= line_trig_pkg::EXP_RUN;
                    end
                end
                line_trig_pkg::EXP_RUN: begin
                    exp_cnt_reg <= exp_cnt_reg + 16'h0001;
                    if (exp_end) begin
                        exp_cnt_reg <= 16'h0001;
                        exp_state_reg <= line_ready_out
                            ? line_trig_pkg::EXP_OVERHEAD
                            : (width_mode ? line_trig_pkg::EXP_RUN
                                          : line_trig_pkg::EXP_HOLD);
                    end
                end
                line_trig_pkg::EXP_HOLD: begin
                    exp_cnt_reg <= 16'h0001;
                    if (line_ready_out) begin
                        exp_state_reg <= line_trig_pkg::EXP_OVERHEAD;
                    end
                end
                line_trig_pkg::EXP_OVERHEAD: begin
                    exp_cnt_reg <= exp_cnt_reg + 16'h0001;
                    if (exp_cnt_reg >= oh_cycles) begin
                        exp_state_reg <= line_trig_pkg::EXP_IDLE;
                    end
                end
                default: exp_state_reg <= line_trig_pkg::EXP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // readout, one line at a time
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ro_busy_reg    <= 1'b0;
            ro_cnt_reg     <= 16'h0000;
            ro_pending_reg <= 1'b0;
        end else begin
            ro_pending_reg <= 1'b0;
            if ((exp_end || exp_state_reg == line_trig_pkg::EXP_HOLD)
                && line_ready_out) begin
                ro_busy_reg <= 1'b1;
                ro_cnt_reg  <= 16'(READOUT_CYCLES);
            end else if (ro_busy_reg) begin
                ro_cnt_reg <= ro_cnt_reg - 16'h0001;
                if (ro_cnt_reg == 16'h0001) begin
                    ro_busy_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // overtrigger accounting and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ovt_line_reg       <= 16'h0000;
            ovt_acq_reg        <= 16'h0000;
            line_overtrigger_o <= 1'b0;
            acq_overtrigger_o  <= 1'b0;
        end else begin
            // line edges in any state but the wait are dropped
            line_overtrigger_o <= ctrl_reg[line_trig_pkg::CTRL_LINE_TRIG]
                                  & line_rise & ~awaiting_line;
            acq_overtrigger_o  <= acq_trig_on & acq_edge
                                  & ~(running_reg & ~armed_reg);
            if (line_overtrigger_o) begin
                ovt_line_reg <= ovt_line_reg + 16'h0001;
            end
            if (acq_overtrigger_o) begin
                ovt_acq_reg <= ovt_acq_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exposure_active_o   <= 1'b0;
            readout_active_o    <= 1'b0;
            line_trigger_wait_o <= 1'b0;
            acq_trigger_wait_o  <= 1'b0;
            frame_start_o       <= 1'b0;
        end else begin
            exposure_active_o   <= (exp_state_reg
                                    == line_trig_pkg::EXP_RUN);
            readout_active_o    <= ro_busy_reg;
            line_trigger_wait_o <= awaiting_line;
            acq_trigger_wait_o  <= running_reg & ~armed_reg & acq_trig_on;
            frame_start_o       <= line_accept & (lines_done_reg == 16'h0);
        end
    end
endmodule : line_trig_ctrl

// ---- dv/trig_src.sv ----
// trigger source model for acquisition and line trigger pins
`timescale 1ns/1ns
module trig_src (
    input  wire logic clk_i,
    input  wire logic wait_i,
    output logic      acq_o,
    output logic      line_o
);
    initial begin
        acq_o = 1'b0;
        line_o = 1'b0;
    end
    // width in cycles; at least 4 so the synchroniser sees the level
    task automatic pulse(input bit on_line, input int width);
        @(posedge clk_i);
        if (on_line)
            line_o <= 1'b1;
        else
            acq_o <= 1'b1;
        repeat (width) @(posedge clk_i);
        line_o <= 1'b0;
        acq_o <= 1'b0;
    endtask : pulse
    // fires as soon as the wait output is up, never faster
    task automatic lines_asap(input int n, input int width);
        repeat (n) begin
            // let the previous accept reach the wait output first
            @(posedge clk_i);
            while (wait_i !== 1'b1) @(posedge clk_i);
            pulse(1'b1, width);
        end
    endtask : lines_asap
endmodule : trig_src

// ---- dv/line_trig_ctrl_chk.sv ----
// assertion checker for the line trigger sequencer ports
`timescale 1ns/1ns
module line_trig_ctrl_chk #(
    parameter int READOUT_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic exposure_active_o,
    input wire logic readout_active_o,
    input wire logic line_trigger_wait_o,
    input wire logic acq_trigger_wait_o,
    input wire logic frame_start_o,
    input wire logic line_overtrigger_o,
    input wire logic acq_overtrigger_o
);
    localparam int OH_MIN = line_trig_pkg::OH_REDUCED_CYC;
    // previous readout may still hold the sensor
    localparam int RO_MAX = 2 * READOUT_CYCLES;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [15:0] gap_reg;
    logic [15:0] ro_reg;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            gap_reg <= 16'hffff;
        else if (exposure_active_o)
            gap_reg <= 16'h0000;
        else if (gap_reg != 16'hffff)
            gap_reg <= gap_reg + 16'h0001;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            ro_reg <= 16'h0000;
        else if (readout_active_o)
            ro_reg <= ro_reg + 16'h0001;
        else
            ro_reg <= 16'h0000;
    end
    sequence s_exp_end;
        $fell(exposure_active_o);
    endsequence
    sequence s_ro_soon;
        ##[0:RO_MAX] readout_active_o;
    endsequence
    property p_wait_excl;
        !(line_trigger_wait_o && acq_trigger_wait_o);
    endproperty
    property p_exp_from_wait;
        $rose(exposure_active_o) |-> $past(line_trigger_wait_o);
    endproperty
    property p_overhead;
        $rose(exposure_active_o) |-> gap_reg >= OH_MIN;
    endproperty
    property p_ro_len;
        $fell(readout_active_o) |-> (ro_reg % READOUT_CYCLES) == 0;
    endproperty
    property p_ro_follows;
        s_exp_end |-> s_ro_soon;
    endproperty
    property p_frame_pulse;
        frame_start_o |=> !frame_start_o;
    endproperty
    property p_frame_run;
        frame_start_o |-> !acq_trigger_wait_o;
    endproperty
    property p_line_ovt;
        line_overtrigger_o |=> !line_overtrigger_o;
    endproperty
    property p_acq_ovt;
        acq_overtrigger_o |=> !acq_overtrigger_o;
    endproperty
    property p_apb_ready;
        psel && !penable |=> pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_wait_excl : assert property (p_wait_excl)
        else $error("both trigger waits high");
    a_exp_from_wait : assert property (p_exp_from_wait)
        else $error("exposure started without line wait");
    a_overhead : assert property (p_overhead)
        else $error("exposure inside overhead");
    a_ro_len : assert property (p_ro_len)
        else $error("readout length off");
    a_ro_follows : assert property (p_ro_follows)
        else $error("no readout after exposure");
    a_frame_pulse : assert property (p_frame_pulse)
        else $error("frame start too long");
    a_frame_run : assert property (p_frame_run)
        else $error("frame started while awaiting acquisition");
    a_line_ovt : assert property (p_line_ovt)
        else $error("line overtrigger too long");
    a_acq_ovt : assert property (p_acq_ovt)
        else $error("acquisition overtrigger too long");
    a_apb_ready : assert property (p_apb_ready)
        else $error("apb answer late");
    a_err_ready : assert property (p_err_ready)
        else $error("apb error outside answer");
endmodule : line_trig_ctrl_chk

bind line_trig_ctrl line_trig_ctrl_chk #(
    .READOUT_CYCLES(READOUT_CYCLES)
) chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .exposure_active_o(exposure_active_o),
    .readout_active_o(readout_active_o),
    .line_trigger_wait_o(line_trigger_wait_o),
    .acq_trigger_wait_o(acq_trigger_wait_o),
    .frame_start_o(frame_start_o),
    .line_overtrigger_o(line_overtrigger_o),
    .acq_overtrigger_o(acq_overtrigger_o)
);

// ---- dv/line_trig_ctrl_tb.sv ----
// self-checking bench for the line trigger sequencer
`timescale 1ns/1ns
module line_trig_ctrl_tb;
    localparam int RO = 200;
    logic        clk_i;
    logic        reset_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        acq;
    logic        line;
    logic        exp_o;
    logic        ro_o;
    logic        lw_o;
    logic        aw_o;
    logic        fs_o;
    logic        lov_o;
    logic        aov_o;
    int          mismatches = 0;
    int          check_count = 0;
    int          exp_n = 0;
    int          fs_n = 0;
    int          len = 0;
    int          last_len = 0;
    logic        ovl = 1'b0;
    line_trig_ctrl #(.READOUT_CYCLES(RO)) DUT (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acq_trigger_input_i(acq),
        .external_line_trigger_input_i(line),
        .exposure_active_o(exp_o), .readout_active_o(ro_o),
        .line_trigger_wait_o(lw_o), .acq_trigger_wait_o(aw_o),
        .frame_start_o(fs_o), .line_overtrigger_o(lov_o),
        .acq_overtrigger_o(aov_o));
    trig_src src (.clk_i(clk_i), .wait_i(lw_o), .acq_o(acq),
        .line_o(line));
    // ------------------------------------------------------------
    // exposure monitor
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (exp_o === 1'b1) begin
            len <= len + 1;
            if (len == 0)
                exp_n <= exp_n + 1;
            if (len == 0 && ro_o === 1'b1)
                ovl <= 1'b1;
        end else if (len != 0) begin
            last_len <= len;
            len <= 0;
        end
        if (fs_o === 1'b1)
            fs_n <= fs_n + 1;
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] want, input logic want_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(n, q, want);
        check({n, " err"}, e, want_err);
    endtask : rd
    task automatic t_regs();
        rd("ctrl", line_trig_pkg::CTRL_ADDR, 32'h06, 1'b0);
        rd("frames", line_trig_pkg::FRAME_CNT_ADDR, 32'h1, 1'b0);
        rd("lines", line_trig_pkg::LINES_ADDR, 32'h3, 1'b0);
        rd("exp", line_trig_pkg::EXP_TIME_ADDR, 32'h28, 1'b0);
        rd("ro us", line_trig_pkg::READOUT_US_ADDR, RO / 20, 1'b0);
        rd("unmapped", 8'h24, 32'h0, 1'b1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_ignore();
        wr(line_trig_pkg::CMD_ADDR, 32'h1);
        repeat (8) @(posedge clk_i);
        check("acq wait", aw_o, 1'b1);
        src.pulse(1'b1, 4);
        repeat (12) @(posedge clk_i);
        check("ignored line", exp_n, 0);
        rd("ovt line", line_trig_pkg::OVT_LINE_ADDR, 32'h1, 1'b0);
        $display("test ignore done");
    endtask : t_ignore
    task automatic t_frames();
        wr(line_trig_pkg::FRAME_CNT_ADDR, 32'h2);
        src.pulse(1'b0, 4);
        repeat (8) @(posedge clk_i);
        check("line wait", lw_o, 1'b1);
        src.pulse(1'b0, 4);
        rd("ovt acq", line_trig_pkg::OVT_ACQ_ADDR, 32'h1, 1'b0);
        src.lines_asap(6, 4);
        for (int i = 0; i < 2000 && aw_o !== 1'b1; i++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        check("acq wait again", aw_o, 1'b1);
        check("frames", fs_n, 2);
        check("exposures", exp_n, 6);
        check("timed length", last_len, 40);
        check("overlap", ovl, 1'b1);
        $display("test frames done");
    endtask : t_frames
    task automatic t_cont();
        int f0;
        int e0;
        f0 = fs_n;
        e0 = exp_n;
        wr(line_trig_pkg::CMD_ADDR, 32'h2);
        wr(line_trig_pkg::CTRL_ADDR, 32'h05);
        wr(line_trig_pkg::CMD_ADDR, 32'h1);
        src.lines_asap(1, 4);
        repeat (5) @(posedge clk_i);
        src.pulse(1'b1, 4);
        repeat (6) @(posedge clk_i);
        rd("ovt line 2", line_trig_pkg::OVT_LINE_ADDR, 32'h2, 1'b0);
        src.lines_asap(6, 4);
        repeat (600) @(posedge clk_i);
        check("cont frames", fs_n - f0, 3);
        check("cont exposures", exp_n - e0, 7);
        wr(line_trig_pkg::CMD_ADDR, 32'h2);
        repeat (8) @(posedge clk_i);
        check("stopped", {lw_o, aw_o}, 2'b00);
        $display("test continuous done");
    endtask : t_cont
    task automatic t_width();
        wr(line_trig_pkg::CTRL_ADDR, 32'h0d);
        wr(line_trig_pkg::CMD_ADDR, 32'h1);
        src.lines_asap(1, 30);
        repeat (12) @(posedge clk_i);
        check("width length", last_len, 30);
        repeat (400) @(posedge clk_i);
        wr(line_trig_pkg::CMD_ADDR, 32'h2);
        $display("test width done");
    endtask : t_width
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // whole run needs well under 8000 cycles
    initial begin
        #1000000;
        mismatches++;
        complete_run();
    end
    initial begin
        reset_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_ignore();
        t_frames();
        t_cont();
        t_width();
        complete_run();
    end
endmodule : line_trig_ctrl_tb
